/* src/emb_timing_map.svh */
`ifndef EMB_TIMING_MAP_SVH
`define EMB_TIMING_MAP_SVH

// one external bus cycle is two core clocks, so a strobe edge at a half cycle
// lands on a whole core clock edge
`define EMB_CLK_PERIOD_NS 10

// tick arithmetic, tick counters are 5 bits wide
`define EMB_TICK_ZERO 5'h00
`define EMB_TICK_ONE 5'h01

// power-up setup of chip select 0 (boot memory)
`define EMB_CS0_WSE_RST 1'b1
`define EMB_CS0_NWS_RST 3'h7
`define EMB_CS0_TDF_RST 3'h0
`define EMB_CS0_BAT_RST 1'b0

// power-up setup of the remaining chip selects
`define EMB_CSX_WSE_RST 1'b0
`define EMB_CSX_NWS_RST 3'h0
`define EMB_CSX_TDF_RST 3'h0
`define EMB_CSX_BAT_RST 1'b0

// global control: standard read protocol after reset
`define EMB_EARLY_READ_RST 1'b0

// float decisions
`define EMB_FLOAT_NONE 3'h0
`define EMB_FLOAT_ONE 3'h1

`endif

/* src/emb_pkg.sv */
`default_nettype none

package emb_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        emb_st_idle = 2'b00,
        emb_st_access = 2'b01,
        emb_st_float = 2'b10
    } emb_state_t;

    // 3-bit per chip select fields (wait count, float cycles)
    typedef logic [2:0] emb_field_t;

    // half-cycle tick counter
    typedef logic [4:0] emb_tick_t;
endpackage : emb_pkg

`default_nettype wire

/* src/emb_bus_cycle.sv */
`include "emb_timing_map.svh"
`default_nettype none

// Notes on behaviour
// RULE_01 - standard read: select and address at start, read strobe in second half only
// RULE_02 - standard read protocol is used while early read select is clear
// RULE_03 - early read select set: read strobe falls at the start of the read
// RULE_04 - early mode back-to-back reads on one select keep read strobe low throughout
// RULE_05 - write: select and address at start, write strobe in second half only
// RULE_06 - zero wait states: write strobe rises at the end of the write cycle
// RULE_07 - each chip select has its own wait enable and 3-bit wait count
// RULE_08 - write strobe low half cycle at zero waits, one cycle per wait otherwise
// RULE_09 - each wait lengthens a read by one cycle; strobe fall point per mode
// RULE_10 - each wait lengthens a write by one cycle; strobe rises half cycle early
// RULE_11 - wait states extend the access itself, not idle gaps between accesses
// RULE_12 - each chip select has a float cycle count from 0 to 7
// RULE_13 - float cycles sit between accesses so the data bus is free
// RULE_14 - same select: none for read-read or write-write, float count for read-write
// RULE_15 - same select write then read: one float in early mode, none in standard
// RULE_16 - new select: max of 1 and old float count after read, one after write
// RULE_17 - the memory releases the data bus within the granted float cycles
// RULE_18 - after reset select 0 has 7 waits, 16-bit, no floats, standard read
// RULE_19 - lane style 0 uses two byte write strobes; 1 uses one strobe plus lane selects
// RULE_20 - wait enable clear means zero wait states whatever the wait count
// RULE_21 - last access select, direction and float count are kept for the next decision
module emb_bus_cycle
    import emb_pkg::*;
#(
    parameter int NUM_CS = 4,
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // global control
    input wire logic mode_write_in,
    input wire logic mode_early_read_select_in,
    // per chip select configuration write
    input wire logic cfg_write_in,
    input wire logic [$clog2(NUM_CS)-1:0] cfg_cs_in,
    input wire logic cfg_wait_insert_enable_in,
    input wire logic [2:0] cfg_wait_count_in,
    input wire logic [2:0] cfg_float_cycles_in,
    input wire logic cfg_byte_lane_style_in,
    // access requests
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic req_write_in,
    input wire logic [$clog2(NUM_CS)-1:0] req_cs_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    input wire logic [1:0] req_byte_en_in,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_rdata_out,
    output logic busy_out,
    output logic early_read_select_out,
    // external memory pins
    output logic [NUM_CS-1:0] chip_select_n_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [DATA_W-1:0] data_in,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic low_byte_write_n_out,
    output logic high_byte_write_n_out,
    output logic upper_lane_sel_n_out,
    output logic lower_lane_sel_n_out
);
    localparam int CSW = $clog2(NUM_CS);

    // configuration store
    logic cfg_wse [NUM_CS];
    emb_field_t cfg_nws [NUM_CS];
    emb_field_t cfg_tdf [NUM_CS];
    logic cfg_bat [NUM_CS];
    logic early_read_select;

    // pending request slot
    logic pend_valid;
    logic pend_write;
    logic [CSW-1:0] pend_cs;
    logic [ADDR_W-1:0] pend_addr;
    logic [DATA_W-1:0] pend_wdata;
    logic [1:0] pend_be;

    // the access on the pins, and the latest one started
    emb_state_t state;
    emb_tick_t tick;
    emb_tick_t last_tick;
    emb_tick_t cur_wlast;
    logic cur_write;
    logic cur_bat;
    logic [1:0] cur_be;
    logic prev_valid;
    logic prev_write;
    logic [CSW-1:0] prev_cs;
    emb_field_t prev_tdf;

    // combinational decisions
    emb_state_t next_state;
    emb_field_t next_float;
    emb_field_t pend_nws;
    logic next_pend_valid;
    logic start_now;
    logic access_end;
    logic accept;

    // float cycles owed between the latest access and the one waiting
    function automatic emb_field_t float_need(
        input logic pv,
        input logic pw,
        input logic [CSW-1:0] pcs,
        input emb_field_t ptdf,
        input logic nw,
        input logic [CSW-1:0] chip_select_n,
        input logic early
    );
        emb_field_t r;
        r = `EMB_FLOAT_NONE;
        if (!pv) begin
            r = `EMB_FLOAT_NONE;
        end else if (pcs == chip_select_n) begin
            if (!pw && nw) begin
                r = ptdf; // RULE_14
            end else if (pw && !nw) begin
                r = early ? `EMB_FLOAT_ONE : `EMB_FLOAT_NONE; // RULE_15
            end else begin
                r = `EMB_FLOAT_NONE; // RULE_14
            end
        end else if (pw) begin
            r = `EMB_FLOAT_ONE; // RULE_16
        end else begin
            r = (ptdf == `EMB_FLOAT_NONE) ? `EMB_FLOAT_ONE : ptdf; // RULE_16
        end
        return r;
    endfunction : float_need

    // per chip select configuration; select 0 wakes up as the boot memory
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < NUM_CS; i++) begin
                cfg_wse[i] <= (i == 0) ? `EMB_CS0_WSE_RST : `EMB_CSX_WSE_RST; // RULE_18
                cfg_nws[i] <= (i == 0) ? `EMB_CS0_NWS_RST : `EMB_CSX_NWS_RST; // RULE_18
                cfg_tdf[i] <= (i == 0) ? `EMB_CS0_TDF_RST : `EMB_CSX_TDF_RST; // RULE_18
                cfg_bat[i] <= (i == 0) ? `EMB_CS0_BAT_RST : `EMB_CSX_BAT_RST; // RULE_18
            end
        end else if (cfg_write_in) begin
            cfg_wse[cfg_cs_in] <= cfg_wait_insert_enable_in; // RULE_07
            cfg_nws[cfg_cs_in] <= cfg_wait_count_in; // RULE_07
            cfg_tdf[cfg_cs_in] <= cfg_float_cycles_in; // RULE_12
            cfg_bat[cfg_cs_in] <= cfg_byte_lane_style_in;
        end
    end

    // global read protocol select, standard after reset
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            early_read_select <= `EMB_EARLY_READ_RST; // RULE_02
            early_read_select_out <= `EMB_EARLY_READ_RST;
        end else if (mode_write_in) begin
            early_read_select <= mode_early_read_select_in;
            early_read_select_out <= mode_early_read_select_in;
        end
    end

    // sequencing decisions; config is sampled at start so later writes never cut an access
    always_comb begin
        pend_nws = cfg_wse[pend_cs] ? cfg_nws[pend_cs] : `EMB_FLOAT_NONE; // RULE_20
        next_float = float_need(prev_valid, prev_write, prev_cs, prev_tdf,
                                pend_write, pend_cs, early_read_select);
        access_end = (state == emb_st_access) && (tick == last_tick);
        start_now = 1'b0;
        next_state = state;
        case (state)
            emb_st_idle: begin
                if (pend_valid) begin
                    start_now = (next_float == `EMB_FLOAT_NONE);
                    next_state = start_now ? emb_st_access : emb_st_float;
                end
            end
            emb_st_access: begin
                if (access_end) begin
                    if (pend_valid) begin
                        // zero float: next access follows on the very next tick
                        start_now = (next_float == `EMB_FLOAT_NONE);
                        next_state = start_now ? emb_st_access : emb_st_float; // RULE_13
                    end else begin
                        next_state = emb_st_idle;
                    end
                end
            end
            emb_st_float: begin
                if (tick == last_tick) begin
                    start_now = 1'b1;
                    next_state = emb_st_access;
                end
            end
            default: begin
                next_state = emb_st_idle;
            end
        endcase
        accept = req_valid_in && req_ready_out;
        next_pend_valid = accept ? 1'b1 : (start_now ? 1'b0 : pend_valid);
    end

    // single request slot; ready drops while it is occupied
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            pend_valid <= 1'b0;
            pend_write <= 1'b0;
            pend_cs <= '0;
            pend_addr <= '0;
            pend_wdata <= '0;
            pend_be <= '0;
            req_ready_out <= 1'b0;
        end else begin
            pend_valid <= next_pend_valid;
            req_ready_out <= !next_pend_valid;
            if (accept) begin
                pend_write <= req_write_in;
                pend_cs <= req_cs_in;
                pend_addr <= req_addr_in;
                pend_wdata <= req_wdata_in;
                pend_be <= req_byte_en_in;
            end
        end
    end

    // state, tick counter and history of the latest started access
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            state <= emb_st_idle;
            tick <= `EMB_TICK_ZERO;
            last_tick <= `EMB_TICK_ZERO;
            cur_wlast <= `EMB_TICK_ONE;
            cur_write <= 1'b0;
            cur_bat <= 1'b0;
            cur_be <= '0;
            prev_valid <= 1'b0;
            prev_write <= 1'b0;
            prev_cs <= '0;
            prev_tdf <= `EMB_FLOAT_NONE;
            busy_out <= 1'b0;
        end else begin
            state <= next_state;
            busy_out <= (next_state != emb_st_idle);
            if (start_now) begin
                tick <= `EMB_TICK_ZERO;
                // two ticks per cycle, one extra cycle per wait, inside the access
                last_tick <= {1'b0, pend_nws, 1'b1}; // RULE_09 RULE_10 RULE_11
                cur_wlast <= (pend_nws == `EMB_FLOAT_NONE) ? `EMB_TICK_ONE
                                                          : {1'b0, pend_nws, 1'b0}; // RULE_08
                cur_write <= pend_write;
                cur_bat <= cfg_bat[pend_cs];
                cur_be <= pend_be;
                prev_valid <= 1'b1; // RULE_21
                prev_write <= pend_write; // RULE_21
                prev_cs <= pend_cs; // RULE_21
                prev_tdf <= cfg_tdf[pend_cs]; // RULE_21
            end else if (next_state == emb_st_float && state != emb_st_float) begin
                // whole float cycles, two ticks each
                tick <= `EMB_TICK_ZERO;
                last_tick <= 5'({1'b0, next_float, 1'b0} - `EMB_TICK_ONE); // RULE_13
            end else if (state != emb_st_idle) begin
                tick <= 5'(tick + `EMB_TICK_ONE);
            end
        end
    end

    // select, address and data pins; the bus is released whenever no access runs
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            chip_select_n_out <= '1;
            addr_out <= '0;
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else if (start_now) begin
            chip_select_n_out <= ~(NUM_CS'(1) << pend_cs); // RULE_01 RULE_05
            addr_out <= pend_addr; // RULE_01 RULE_05
            data_out <= pend_wdata;
            data_oe_out <= pend_write;
        end else if (access_end) begin
            // data drive ends with the write so the memory side sees a free bus
            chip_select_n_out <= '1;
            data_oe_out <= 1'b0; // RULE_13
        end
    end

    // read strobe; standard mode waits half a cycle to stay clear of the last driver
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            read_strobe_n_out <= 1'b1;
        end else if (start_now) begin
            // early mode: low from tick 0, so back-to-back reads never release it
            read_strobe_n_out <= !(!pend_write && early_read_select); // RULE_01 RULE_03 RULE_04
        end else if (state == emb_st_access && !access_end) begin
            read_strobe_n_out <= cur_write; // RULE_09
        end else begin
            read_strobe_n_out <= 1'b1;
        end
    end

    // write strobes and lane selects; tick 0 never writes so setup is half a cycle
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            write_strobe_n_out <= 1'b1;
            low_byte_write_n_out <= 1'b1;
            high_byte_write_n_out <= 1'b1;
            upper_lane_sel_n_out <= 1'b1;
            lower_lane_sel_n_out <= 1'b1;
        end else if (start_now) begin
            write_strobe_n_out <= 1'b1; // RULE_05
            low_byte_write_n_out <= 1'b1;
            high_byte_write_n_out <= 1'b1;
            // lane selects cover the whole access, reads and writes alike
            upper_lane_sel_n_out <= !(cfg_bat[pend_cs] && pend_be[1]); // RULE_19
            lower_lane_sel_n_out <= !(cfg_bat[pend_cs] && pend_be[0]); // RULE_19
        end else if (state == emb_st_access && !access_end) begin
            // strobe active on ticks 1..wlast, high for the final half cycle with waits
            write_strobe_n_out <= !(cur_write && cur_bat &&
                                    (5'(tick + `EMB_TICK_ONE) <= cur_wlast)); // RULE_06 RULE_10
            low_byte_write_n_out <= !(cur_write && !cur_bat && cur_be[0] &&
                                      (5'(tick + `EMB_TICK_ONE) <= cur_wlast)); // RULE_19
            high_byte_write_n_out <= !(cur_write && !cur_bat && cur_be[1] &&
                                       (5'(tick + `EMB_TICK_ONE) <= cur_wlast)); // RULE_19
        end else begin
            write_strobe_n_out <= 1'b1; // RULE_06
            low_byte_write_n_out <= 1'b1;
            high_byte_write_n_out <= 1'b1;
            upper_lane_sel_n_out <= 1'b1;
            lower_lane_sel_n_out <= 1'b1;
        end
    end

    // read data is taken on the edge that closes the access
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rsp_valid_out <= 1'b0;
            rsp_rdata_out <= '0;
        end else begin
            rsp_valid_out <= access_end && !cur_write;
            if (access_end && !cur_write) begin
                rsp_rdata_out <= data_in;
            end
        end
    end

endmodule : emb_bus_cycle

`default_nettype wire

/* test/emb_bus_cycle_props.sv */
`default_nettype none

// pin timing relations of one external bus cycle unit
module emb_bus_cycle_props #(
    parameter int NUM_CS = 4
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic rsp_valid_out,
    input wire logic busy_out,
    input wire logic early_read_select_out,
    input wire logic [NUM_CS-1:0] chip_select_n_out,
    input wire logic data_oe_out,
    input wire logic read_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic low_byte_write_n_out,
    input wire logic high_byte_write_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cs_idle;
    logic wr_n;
    // any write lane counts, so both lane styles share one set of checks
    assign cs_idle = &chip_select_n_out;
    assign wr_n = write_strobe_n_out & low_byte_write_n_out & high_byte_write_n_out;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    // longest access is seven waits, two ticks each plus two
    sequence s_rsp_soon; ##[1:16] rsp_valid_out; endsequence
    sequence s_wr_up; ##[1:14] $rose(wr_n); endsequence
    property p_std_rd; $fell(read_strobe_n_out) && !early_read_select_out |-> !$past(cs_idle); endproperty
    property p_early_rd; $fell(read_strobe_n_out) && early_read_select_out |-> $past(cs_idle); endproperty
    property p_rd_done; $fell(read_strobe_n_out) |-> s_rsp_soon; endproperty
    property p_rsp_src; rsp_valid_out |-> !$past(read_strobe_n_out); endproperty
    property p_wr_len; $fell(wr_n) |-> s_wr_up; endproperty
    property p_wr_late; $fell(wr_n) |-> !$past(cs_idle) && !cs_idle && data_oe_out; endproperty
    property p_wr_end; $rose(cs_idle) |-> wr_n; endproperty
    property p_rd_float; !read_strobe_n_out |-> !data_oe_out && !cs_idle; endproperty
    property p_busy; !cs_idle |-> busy_out; endproperty
    property p_lane; !write_strobe_n_out |-> low_byte_write_n_out && high_byte_write_n_out; endproperty
    a_std_rd: assert property (p_std_rd) else $error("read strobe in first half");
    a_early_rd: assert property (p_early_rd) else $error("early strobe late");
    a_rd_done: assert property (p_rd_done) else $error("read never answered");
    a_rsp_src: assert property (p_rsp_src) else $error("answer without strobe");
    a_wr_len: assert property (p_wr_len) else $error("write pulse too long");
    a_wr_late: assert property (p_wr_late) else $error("write strobe in first half");
    a_wr_end: assert property (p_wr_end) else $error("write outlasts select");
    a_rd_float: assert property (p_rd_float) else $error("read while driving");
    a_busy: assert property (p_busy) else $error("select low while idle");
    a_lane: assert property (p_lane) else $error("lane strobes mixed");
endmodule : emb_bus_cycle_props

`default_nettype wire

/* test/emb_mem_model.sv */
`default_nettype none

// sixteen word asynchronous memory shared by every select
module emb_mem_model (
    input wire logic sys_clk_in,
    input wire logic [3:0] chip_select_n_in,
    input wire logic [19:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    input wire logic low_byte_write_n_in,
    input wire logic high_byte_write_n_in,
    input wire logic upper_lane_sel_n_in,
    input wire logic lower_lane_sel_n_in,
    output logic [15:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] junk = 16'h5a3c;
    logic sel, lo, hi;
    // lane enables for both lane styles
    assign sel = ~&chip_select_n_in;
    assign lo = sel & (~low_byte_write_n_in | (~write_strobe_n_in & ~lower_lane_sel_n_in));
    assign hi = sel & (~high_byte_write_n_in | (~write_strobe_n_in & ~upper_lane_sel_n_in));
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
    end
    // lanes latch while their strobe is low; junk changes every cycle
    always @(posedge sys_clk_in) begin
        junk <= ~junk ^ 16'h0101;
        if (lo) mem[addr_in[3:0]][7:0] <= wdata_in[7:0];
        if (hi) mem[addr_in[3:0]][15:8] <= wdata_in[15:8];
    end
    // a released bus never shows the last word, so a late sample fails
    assign rdata_out = (sel && !read_strobe_n_in) ? mem[addr_in[3:0]] : junk;
endmodule : emb_mem_model

`default_nettype wire

/* test/tb_ext_mem_bus_cycle_timing.sv */
`default_nettype none

module tb_ext_mem_bus_cycle_timing;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] d; int off;} emb_note_t;
    logic sys_clk_in, resetn_in, mode_write, mode_early, cfg_write, cfg_wse, cfg_lane, req_valid, req_write;
    logic req_ready, rsp_valid, busy, ers, data_oe, rd_n, we_n, wlo_n, whi_n, ub_n, lb_n, armed, wa, wb;
    logic [1:0] cfg_cs, req_cs, req_be;
    logic [2:0] cfg_nws, cfg_tdf;
    logic [3:0] cs_n, a;
    logic [19:0] req_addr, addr;
    logic [15:0] req_wdata, data_in, rdata, data_out;
    logic [63:0] h_cs, h_rd, h_wr;
    logic [15:0] shadow [16];
    logic cw [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    int cn [4] = '{7, 0, 0, 0};
    int ct [4] = '{0, 0, 0, 0};
    int n_errors = 0, num_checks = 0, cyc = 0, t0 = 0, seed = 32'hdc653fc0, e, ca, cb, f, la, b0;
    emb_note_t notes [$];
    emb_note_t nt;

    emb_bus_cycle u_dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .mode_write_in(mode_write),
        .mode_early_read_select_in(mode_early), .cfg_write_in(cfg_write), .cfg_cs_in(cfg_cs),
        .cfg_wait_insert_enable_in(cfg_wse), .cfg_wait_count_in(cfg_nws), .cfg_float_cycles_in(cfg_tdf),
        .cfg_byte_lane_style_in(cfg_lane), .req_valid_in(req_valid), .req_ready_out(req_ready),
        .req_write_in(req_write), .req_cs_in(req_cs), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
        .req_byte_en_in(req_be), .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata), .busy_out(busy),
        .early_read_select_out(ers), .chip_select_n_out(cs_n), .addr_out(addr), .data_out(data_out),
        .data_oe_out(data_oe), .data_in(data_in), .read_strobe_n_out(rd_n), .write_strobe_n_out(we_n),
        .low_byte_write_n_out(wlo_n), .high_byte_write_n_out(whi_n), .upper_lane_sel_n_out(ub_n),
        .lower_lane_sel_n_out(lb_n)
    );
    emb_mem_model u_mem (
        .sys_clk_in(sys_clk_in), .chip_select_n_in(cs_n), .addr_in(addr), .wdata_in(data_out),
        .read_strobe_n_in(rd_n), .write_strobe_n_in(we_n), .low_byte_write_n_in(wlo_n),
        .high_byte_write_n_in(whi_n), .upper_lane_sel_n_in(ub_n), .lower_lane_sel_n_in(lb_n),
        .rdata_out(data_in)
    );

    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        num_checks++;
        if (s !== x) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk

    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // access length in ticks; a cleared enable ignores the count
    function automatic int wlen(input int c);
        return cw[c] ? 2 * cn[c] + 2 : 2;
    endfunction : wlen

    // new setup for one select; the caller drops the pulse
    task automatic cfgw(input int c);
        cw[c] = 1'($random(seed));
        cn[c] = $random(seed) & 7;
        ct[c] = $random(seed) & 7;
        cfg_write <= 1'b1;
        cfg_cs <= 2'(c);
        cfg_wse <= cw[c];
        cfg_nws <= 3'(cn[c]);
        cfg_tdf <= 3'(ct[c]);
        cfg_lane <= 1'($random(seed));
        @(posedge sys_clk_in);
    endtask : cfgw

    // holds one request until the edge that takes it; valid stays up
    task automatic put(input logic w, input int c, input int off);
        logic [15:0] d;
        logic [1:0] be;
        d = 16'($random(seed));
        be = 2'($random(seed));
        if (be == 2'h0) be = 2'h3;
        if (w && be[0]) shadow[a][7:0] = d[7:0];
        if (w && be[1]) shadow[a][15:8] = d[15:8];
        if (!w) notes.push_back('{shadow[a], off});
        // byte enables go out on the edge like every other request field
        req_valid <= 1'b1;
        req_be <= be;
        req_write <= w;
        req_cs <= 2'(c);
        req_addr <= {16'($random(seed)), a};
        req_wdata <= d;
        @(negedge sys_clk_in);
        for (int k = 0; k < 100 && req_ready !== 1'b1; k++) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
    endtask : put

    task automatic idle();
        @(negedge sys_clk_in);
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(negedge sys_clk_in);
        @(posedge sys_clk_in);
    endtask : idle

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // pins sampled mid-cycle, indexed from the first select of a pair
    always @(negedge sys_clk_in) begin
        cyc++;
        if (armed && !(&cs_n)) begin
            t0 = cyc;
            armed = 1'b0;
        end
        if (!armed && cyc - t0 < 64) begin
            h_cs[cyc - t0] = ~&cs_n;
            h_rd[cyc - t0] = ~rd_n;
            h_wr[cyc - t0] = ~(we_n & wlo_n & whi_n);
        end
        if (rsp_valid === 1'b1) begin
            nt = notes.size() > 0 ? notes.pop_front() : emb_note_t'{16'hdead, -1};
            chk(rdata, nt.d);
            chk(16'(cyc - t0), 16'(nt.off));
        end
    end

    initial begin
        {mode_write, mode_early, cfg_write, cfg_wse, cfg_lane, req_valid, req_write, armed} = '0;
        {cfg_cs, req_cs, req_be, cfg_nws, cfg_tdf, req_addr, req_wdata, a} = '0;
        resetn_in = 1'b0;
        for (int i = 0; i < 16; i++) shadow[i] = 16'h0000;
        repeat (8) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
        // pair zero runs on the power-up setup of select 0
        for (int it = 0; it < 48; it++) begin
            {e, ca, cb, wa, wb} = '0;
            if (it > 0) begin
                e = $random(seed) & 1;
                ca = $random(seed) & 3;
                cb = ($random(seed) & 1) ? ca : (ca + 1) & 3;
                wa = 1'($random(seed));
                wb = 1'($random(seed));
                mode_write <= 1'b1;
                mode_early <= 1'(e);
                cfgw(ca);
                if (cb != ca) cfgw(cb);
                mode_write <= 1'b0;
                cfg_write <= 1'b0;
            end
            idle();
            chk(16'(ers), 16'(e));
            if (ca == cb) f = wa ? (wb ? 0 : e) : (wb ? ct[ca] : 0);
            else f = wa ? 1 : (ct[ca] > 1 ? ct[ca] : 1);
            la = wlen(ca);
            b0 = la + 2 * f;
            a = 4'($random(seed));
            {h_cs, h_rd, h_wr} = '0;
            armed = 1'b1;
            put(wa, ca, la);
            put(wb, cb, b0 + wlen(cb));
            req_valid <= 1'b0;
            idle();
            chk(16'(h_cs[la - 1]), 16'h1);
            chk(16'(h_cs[b0]), 16'h1);
            if (f > 0) chk(16'(h_cs[b0 - 1] | h_cs[la]), 16'h0);
            if (!wb) begin
                chk(16'(h_rd[b0]), 16'(e));
                chk(16'(h_rd[b0 + 1]), 16'h1);
                if (e && !wa && ca == cb) chk(16'(h_rd[b0 - 1]), 16'h1);
            end else begin
                chk(16'(h_wr[b0]), 16'h0);
                chk(16'(h_wr[b0 + wlen(cb) - 2]), 16'(wlen(cb) > 2));
                chk(16'(h_wr[b0 + wlen(cb) - 1]), 16'(wlen(cb) == 2));
            end
        end
        // every read that was asked for must have been answered
        chk(16'(notes.size()), 16'h0);
        test_done();
    end

    // about fifty pairs of a hundred cycles each fit well inside this
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
endmodule : tb_ext_mem_bus_cycle_timing

bind emb_bus_cycle emb_bus_cycle_props #(.NUM_CS(NUM_CS)) u_props (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .rsp_valid_out(rsp_valid_out), .busy_out(busy_out),
    .early_read_select_out(early_read_select_out), .chip_select_n_out(chip_select_n_out),
    .data_oe_out(data_oe_out), .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
    .low_byte_write_n_out(low_byte_write_n_out), .high_byte_write_n_out(high_byte_write_n_out)
);

`default_nettype wire
